//--- include/wsgen_regs.svh
// offsets, field positions, reset values and limits of the wait-state generator.
// assumes it is included by its bare name from the package or a module.
`ifndef WSGEN_REGS_SVH
`define WSGEN_REGS_SVH

// ----------------------------------------
// register offsets (memory-mapped word addresses)
// ----------------------------------------
`define WSGEN_RANGE_OFS 8'h28
`define WSGEN_MULT_OFS 8'h2B

// ----------------------------------------
// field positions of the range-count and multiplier registers
// ----------------------------------------
`define WSGEN_PROG_LO_LSB 0
`define WSGEN_PROG_HI_LSB 3
`define WSGEN_DATA_LO_LSB 6
`define WSGEN_DATA_HI_LSB 9
`define WSGEN_IO_LSB 12
`define WSGEN_XPA_BIT 15
`define WSGEN_DOUBLE_BIT 0

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define WSGEN_RANGE_RST 16'h7FFF
`define WSGEN_MULT_RST 16'h0000
`define WSGEN_MAX_WAITS 14

`endif

//--- include/wsgen_pkg.sv
// types shared by the wait-state generator files.
// assumes wsgen_regs.svh sits on the include path.
`include "wsgen_regs.svh"

package wsgen_pkg;

  // ----------------------------------------
  // external access space
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    WSGEN_SP_PROG,
    WSGEN_SP_DATA,
    WSGEN_SP_IO
  } wsgen_space_e;

  typedef logic [2:0] wsgen_base_t;
  typedef logic [3:0] wsgen_wait_t;

endpackage : wsgen_pkg

//--- rtl/wsgen_regfile.sv
// one subsystem's pair of wait-state registers on the memory-mapped port.
// assumes single-cycle writes and reads from the local cpu on ref_clk.
`timescale 1ns/1ps

module wsgen_regfile
  import wsgen_pkg::*;
(
  input wire logic ref_clk, // machine-cycle clock
  input wire logic nrst, // async reset, active low
  input wire logic wr_en, // write strobe, one cycle
  input wire logic [7:0] addr, // register word address
  input wire logic [15:0] wdata, // write data
  output logic [15:0] range_q, // range-count register
  output logic [15:0] mult_q // multiplier control register
);

  logic [15:0] range_d;
  logic [15:0] mult_d;

  // ----------------------------------------
  // register update
  // ----------------------------------------
  always_comb
  begin
    range_d = range_q;
    mult_d = mult_q;
    if (wr_en && (addr == `WSGEN_RANGE_OFS))
    begin
      range_d = wdata;
    end
    if (wr_en && (addr == `WSGEN_MULT_OFS))
    begin
      // reserved bits stay zero whatever is written
      mult_d = {15'h0000, wdata[`WSGEN_DOUBLE_BIT]};
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      range_q <= `WSGEN_RANGE_RST;
      mult_q <= `WSGEN_MULT_RST;
    end
    else
    begin
      range_q <= range_d;
      mult_q <= mult_d;
    end
  end

endmodule : wsgen_regfile

//--- rtl/wsgen_counter.sv
// down-counter that holds an access until its wait states are spent.
// assumes start only arrives while idle.
`timescale 1ns/1ps

module wsgen_counter
  import wsgen_pkg::*;
(
  input wire logic ref_clk, // machine-cycle clock
  input wire logic nrst, // async reset, active low
  input wire logic start, // access begins, one cycle
  input wire wsgen_wait_t load, // wait count for this access
  output logic busy_q // waits still running
);

  wsgen_wait_t cnt_q;
  wsgen_wait_t cnt_d;
  logic busy_d;

  // ----------------------------------------
  // count
  // ----------------------------------------
  always_comb
  begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    if (start)
    begin
      // count latched here, so later writes leave this access alone
      cnt_d = load;
      busy_d = (load != 4'h0);
    end
    else if (busy_q)
    begin
      cnt_d = cnt_q - 4'h1;
      busy_d = (cnt_q > 4'h1);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
    end
  end

endmodule : wsgen_counter

//--- rtl/wsgen_top.sv
// programmable wait-state generator for a two-subsystem external interface.
// assumes the arbiter grant is stable while an access is requested.
//
// How it works
// - each external bus cycle is stretched by up to fourteen wait states
// - low 15 bits hold five 3-bit base counts, one per range
// - each subsystem owns registers; arbiter grant picks the copy applied
// - reset gives seven waits everywhere; extension and doubling bits clear
// - bit 15 is read/write program-extension select, reset zero
// - bits 14..12 set waits for all I/O accesses
// - bits 11..9 set waits for data 8000..FFFF
// - bits 8..6 set waits for data 0000..7FFF
// - bits 5..3 cover program upper half-page; unused when extension set
// - bits 2..0 cover program lower half-page, or everything when extension set
// - multiplier bit 0 doubles base counts when set
// - multiplier bits 15..1 read zero, ignore writes
`timescale 1ns/1ps

module wsgen_top
  import wsgen_pkg::*;
#(
  parameter int NUM_SUBSYS = 2, // subsystems sharing the interface
  parameter int ADDR_W = 16 // external access offset width
)
(
  input wire logic ref_clk, // machine-cycle clock
  input wire logic nrst, // async reset, active low
  input wire logic [NUM_SUBSYS-1:0] reg_wr, // per-subsystem write strobe
  input wire logic [NUM_SUBSYS-1:0] reg_rd, // per-subsystem read strobe
  input wire logic [7:0] reg_addr, // register word address
  input wire logic [15:0] reg_wdata, // write data
  output logic [15:0] reg_rdata_q, // read data, one cycle after strobe
  input wire logic arb_grant, // shared_interface_arbiter owner index
  input wire logic acc_start, // external access begins, one cycle
  input wire logic [1:0] acc_space, // wsgen_space_e of the access
  input wire logic [ADDR_W-1:0] acc_addr, // low address bits of the access
  output logic acc_wait_q, // bus held in wait states
  output logic [3:0] acc_count_q // wait count granted to last access
);

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  initial
  begin
    if (NUM_SUBSYS != 2)
    begin
      $error("wsgen_top serves exactly two subsystems");
    end
    if (ADDR_W < 16)
    begin
      $error("wsgen_top needs at least 16 address bits");
    end
  end

  // ----------------------------------------
  // per-subsystem register copies
  // ----------------------------------------
  logic [15:0] range_q [NUM_SUBSYS];
  logic [15:0] mult_q [NUM_SUBSYS];

  genvar g;
  generate
    for (g = 0; g < NUM_SUBSYS; g++)
    begin : g_regs
      wsgen_regfile u_regs
      (
        .ref_clk (ref_clk),
        .nrst (nrst),
        .wr_en (reg_wr[g]),
        .addr (reg_addr),
        .wdata (reg_wdata),
        .range_q (range_q[g]),
        .mult_q (mult_q[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // read port
  // ----------------------------------------
  function automatic logic [15:0] read_reg(input logic [7:0] a, input logic [15:0] r, input logic [15:0] m);
    logic [15:0] v;
    v = 16'h0000;
    if (a == `WSGEN_RANGE_OFS)
    begin
      v = r;
    end
    else if (a == `WSGEN_MULT_OFS)
    begin
      v = m;
    end
    return v;
  endfunction : read_reg

  logic [15:0] rdata_d;

  always_comb
  begin
    rdata_d = reg_rdata_q;
    if (reg_rd[1])
    begin
      rdata_d = read_reg(reg_addr, range_q[1], mult_q[1]);
    end
    else if (reg_rd[0])
    begin
      rdata_d = read_reg(reg_addr, range_q[0], mult_q[0]);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata_q <= 16'h0000;
    end
    else
    begin
      reg_rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // range selection
  // ----------------------------------------
  logic [15:0] sel_range;
  logic sel_double;
  wsgen_base_t base;
  wsgen_wait_t waits_d;
  logic upper_half;

  always_comb
  begin
    sel_range = range_q[arb_grant];
    sel_double = mult_q[arb_grant][`WSGEN_DOUBLE_BIT];
    upper_half = acc_addr[15];
    base = sel_range[`WSGEN_PROG_LO_LSB +: 3];
    case (wsgen_space_e'(acc_space))
      WSGEN_SP_IO:
      begin
        base = sel_range[`WSGEN_IO_LSB +: 3];
      end
      WSGEN_SP_DATA:
      begin
        if (upper_half)
        begin
          base = sel_range[`WSGEN_DATA_HI_LSB +: 3];
        end
        else
        begin
          base = sel_range[`WSGEN_DATA_LO_LSB +: 3];
        end
      end
      WSGEN_SP_PROG:
      begin
        // extension set: low field covers the whole program space
        if (upper_half && !sel_range[`WSGEN_XPA_BIT])
        begin
          base = sel_range[`WSGEN_PROG_HI_LSB +: 3];
        end
        else
        begin
          base = sel_range[`WSGEN_PROG_LO_LSB +: 3];
        end
      end
      default:
      begin
        base = sel_range[`WSGEN_PROG_LO_LSB +: 3];
      end
    endcase
    // doubling tops out at 14
    waits_d = sel_double ? {base, 1'b0} : {1'b0, base};
  end

  // ----------------------------------------
  // wait counting
  // ----------------------------------------
  // the counter's own busy flop is the hold output, so no copy can drift from it
  wsgen_counter u_cnt
  (
    .ref_clk (ref_clk),
    .nrst (nrst),
    .start (acc_start),
    .load (waits_d),
    .busy_q (acc_wait_q)
  );

  logic [3:0] count_d;

  always_comb
  begin
    count_d = acc_start ? waits_d : acc_count_q;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      acc_count_q <= 4'h0;
    end
    else
    begin
      acc_count_q <= count_d;
    end
  end

endmodule : wsgen_top

//--- tb/wsgen_mem_model.sv
// slow external device seen through the wait-state hold.
// assumes it samples the hold on the same ref_clk as the generator.
`timescale 1ns/1ps
module wsgen_mem_model
(
  input wire logic ref_clk, // clock
  input wire logic nrst, // reset, active low
  input wire logic acc_wait_q, // hold from generator
  output int waits_seen // length of last hold
);
  int run;
  // ------
  // the device answers only once the hold ends
  // ------
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      run <= 0;
    else if (acc_wait_q)
      run <= run + 1;
    else if (run != 0)
    begin
      waits_seen <= run;
      run <= 0;
    end
  end
endmodule : wsgen_mem_model

//--- tb/wsgen_checker.sv
// port-level assertions for the wait-state generator.
// assumes it is bound onto wsgen_top.
`timescale 1ns/1ps
module wsgen_checker
  import wsgen_pkg::*;
#(
  parameter int NUM_SUBSYS = 2, // subsystems
  parameter int ADDR_W = 16 // offset width
)
(
  input wire logic ref_clk, // clock
  input wire logic nrst, // reset
  input wire logic [NUM_SUBSYS-1:0] reg_wr, // write strobes
  input wire logic [NUM_SUBSYS-1:0] reg_rd, // read strobes
  input wire logic [7:0] reg_addr, // address
  input wire logic [15:0] reg_wdata, // write data
  input wire logic [15:0] reg_rdata_q, // read data
  input wire logic arb_grant, // owner
  input wire logic acc_start, // access start
  input wire logic [1:0] acc_space, // space
  input wire logic [ADDR_W-1:0] acc_addr, // offset
  input wire logic acc_wait_q, // hold
  input wire logic [3:0] acc_count_q // granted count
);
  // ------
  // helper: length of the running hold
  // ------
  logic [4:0] run_d;
  logic [4:0] run_q;
  always_comb run_d = acc_wait_q ? run_q + 5'h1 : 5'h0;
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      run_q <= 5'h0;
    else
      run_q <= run_d;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  sequence s_two;
    acc_start ##1 acc_count_q == 4'h2;
  endsequence
  chk_count_max: assert property (acc_start |=> acc_count_q <= 4'hE)
    else $error("count above limit");
  chk_wait_begin: assert property (acc_start |=> acc_wait_q == (acc_count_q != 4'h0))
    else $error("hold start wrong");
  chk_wait_len: assert property ($fell(acc_wait_q) |-> run_q == {1'b0, acc_count_q})
    else $error("hold length wrong");
  chk_two_waits: assert property (s_two |-> acc_wait_q [*2] ##1 !acc_wait_q)
    else $error("two-wait hold wrong");
  chk_idle_quiet: assert property (!acc_start && !acc_wait_q |=> !acc_wait_q)
    else $error("hold without start");
  chk_count_hold: assert property (!acc_start |=> $stable(acc_count_q))
    else $error("count changed mid access");
  chk_rsvd_zero: assert property (|reg_rd && reg_addr == 8'h2B |=> reg_rdata_q[15:1] == 15'h0)
    else $error("reserved bits nonzero");
  chk_unmapped_zero: assert property (|reg_rd && reg_addr != 8'h28 && reg_addr != 8'h2B |=> reg_rdata_q == 16'h0)
    else $error("unmapped read nonzero");
  chk_rdata_hold: assert property (!(|reg_rd) |=> $stable(reg_rdata_q))
    else $error("read data moved");
endmodule : wsgen_checker
bind wsgen_top wsgen_checker #(.NUM_SUBSYS(NUM_SUBSYS), .ADDR_W(ADDR_W)) chk_u (.ref_clk(ref_clk), .nrst(nrst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
  .arb_grant(arb_grant), .acc_start(acc_start), .acc_space(acc_space), .acc_addr(acc_addr),
  .acc_wait_q(acc_wait_q), .acc_count_q(acc_count_q));

//--- tb/wsgen_top_tb.sv
// self-checking bench for the wait-state generator.
// assumes design, checker and memory model are compiled first.
`timescale 1ns/1ps
module wsgen_top_tb
  import wsgen_pkg::*;
;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] reg_wr = 2'h0;
  logic [1:0] reg_rd = 2'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic arb_grant = 1'b0;
  logic acc_start = 1'b0;
  logic [1:0] acc_space = 2'h0;
  logic [15:0] acc_addr = 16'h0000;
  logic [15:0] reg_rdata_q;
  logic acc_wait_q;
  logic [3:0] acc_count_q;
  int waits_seen, n_mismatch, total_checks, cyc, g;
  int rng [2] = '{32'h7FFF, 32'h7FFF};
  int mul [2] = '{0, 0};
  wsgen_top #(.NUM_SUBSYS(2), .ADDR_W(16)) dut_u (.ref_clk(ref_clk), .nrst(nrst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .arb_grant(arb_grant), .acc_start(acc_start), .acc_space(acc_space), .acc_addr(acc_addr),
    .acc_wait_q(acc_wait_q), .acc_count_q(acc_count_q));
  wsgen_mem_model mem_u (.ref_clk(ref_clk), .nrst(nrst), .acc_wait_q(acc_wait_q), .waits_seen(waits_seen));
  always #5 ref_clk = ~ref_clk;
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input int s, input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 2'h1 << s;
    reg_addr <= a;
    reg_wdata <= d;
    if (a == 8'h28)
      rng[s] = d;
    if (a == 8'h2B)
      mul[s] = d & 1;
    @(posedge ref_clk);
    reg_wr <= 2'h0;
  endtask : wr
  task automatic rd(input int s, input logic [7:0] a);
    int e;
    e = a == 8'h28 ? rng[s] : a == 8'h2B ? mul[s] : 0;
    @(posedge ref_clk);
    reg_rd <= 2'h1 << s;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 2'h0;
    #1;
    chk(reg_rdata_q, e[15:0]);
  endtask : rd
  task automatic acc(input int s, input int sp, input logic [15:0] a);
    int r, b, n;
    r = rng[s];
    b = sp == 1 ? (a[15] ? r[11:9] : r[8:6]) : sp == 2 ? r[14:12] : (r[15] || !a[15]) ? r[2:0] : r[5:3];
    n = mul[s] ? 2 * b : b;
    @(posedge ref_clk);
    arb_grant <= s[0];
    acc_space <= sp[1:0];
    acc_addr <= a;
    acc_start <= 1'b1;
    @(posedge ref_clk);
    acc_start <= 1'b0;
    #1;
    chk(acc_count_q, n[15:0]);
    b = 0;
    while (acc_wait_q === 1'b1 && b < 20)
    begin
      b++;
      @(posedge ref_clk);
      #1;
    end
    chk(b[15:0], n[15:0]);
    @(posedge ref_clk);
    #1;
    if (n > 0)
      chk(waits_seen[15:0], n[15:0]);
  endtask : acc
  initial
  begin
    void'($urandom(32'h3E91));
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int s = 0; s < 2; s++)
      for (int sp = 0; sp < 3; sp++)
      begin
        rd(s, 8'h28);
        rd(s, 8'h2B);
        acc(s, sp, 16'hFFFF);
      end
    // unmapped write to subsystem 0, then a read of that unmapped address must return zero
    wr(0, 8'h29, 16'h0000);
    rd(0, 8'h29);
    for (int i = 0; i < 40; i++)
    begin
      g = $urandom_range(1);
      wr($urandom_range(1), 8'h28, 16'($urandom));
      wr($urandom_range(1), 8'h2B, 16'($urandom));
      acc(g, $urandom_range(2), 16'($urandom));
      rd(g, 8'h28);
      rd(g, 8'h2B);
    end
    end_sim();
  end
endmodule : wsgen_top_tb
